// ===== ihc_pkg.sv
// Shared constants and types for the host command port
package ihc_pkg;
  typedef logic [7:0] ihc_byte_t;
  typedef logic [6:0] ihc_addr_t;

  // ==========================================
  // Addressing and bit framing
  localparam ihc_addr_t SLAVE_ADDR = 7'h40;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [4:0] ADDR_ACK_BIT = 5'h08;
  localparam logic [4:0] LAST_BIT = 5'h11;
  localparam logic [4:0] FIRST_RX_BIT = 5'h09;
  localparam logic [4:0] LAST_RX_BIT = 5'h10;

  // ==========================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int FAST_KBPS = 400;
  localparam int SPIKE_NS = 50;
  // Least stable time: round up
  localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] SPIKE_LAST = 4'(SPIKE_CYC - 1);
  // Quarter bit rounds up so the rate never exceeds fast mode
  localparam int QTR_CYC = (CLK_MHZ * 1000 + 4 * FAST_KBPS - 1) / (4 * FAST_KBPS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
endpackage

// ===== ihc_if.sv
// Slave pin pair and notify pin joining host and device
interface ihc_if;
  logic hostSclO;
  logic hostSclOe;
  logic hostSdaO;
  logic hostSdaOe;
  logic devSclO;
  logic devSclOe;
  logic devSdaO;
  logic devSdaOe;
  logic scl;
  logic sda;
  logic messagePendingNotifyPin;

  // Open-drain wired AND with pull-up
  assign scl = (hostSclOe ? hostSclO : 1'b1) & (devSclOe ? devSclO : 1'b1);
  assign sda = (hostSdaOe ? hostSdaO : 1'b1) & (devSdaOe ? devSdaO : 1'b1);

  modport dev (
    input scl,
    input sda,
    output devSclO,
    output devSclOe,
    output devSdaO,
    output devSdaOe,
    output messagePendingNotifyPin
  );
  modport host (
    input scl,
    input sda,
    input messagePendingNotifyPin,
    output hostSclO,
    output hostSclOe,
    output hostSdaO,
    output hostSdaOe
  );
endinterface

// ===== ihc_host.sv
// Host end: drives the slave pin pair as bus master
module ihc_host (
  input wire logic clk,
  input wire logic srst,
  ihc_if.host link,
  input wire logic req,
  input wire logic rdNotWr,
  input wire ihc_pkg::ihc_byte_t wrByte,
  output logic busy,
  output logic done,
  output logic nack,
  output ihc_pkg::ihc_byte_t rdByte,
  output logic msgPendingSeen
);
  import ihc_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} ihc_hstate_e;

  // ==========================================
  // Pin synchronisers
  logic sclMeta_r, sclSync_r, sdaMeta_r, sdaSync_r, ntfMeta_r, ntfSync_r;
  always_ff @(posedge clk) begin
    sclMeta_r <= link.scl;
    sclSync_r <= sclMeta_r;
    sdaMeta_r <= link.sda;
    sdaSync_r <= sdaMeta_r;
    ntfMeta_r <= link.messagePendingNotifyPin;
    ntfSync_r <= ntfMeta_r;
  end

  // ==========================================
  // Bit engine
  ihc_hstate_e state_r;
  logic [7:0] qCnt_r;
  logic [1:0] ph_r;
  logic [4:0] idx_r;
  logic [17:0] frame_r;
  logic sclOe_r, sdaOe_r, done_r, nack_r, rd_r;
  ihc_byte_t rx_r;
  wire tick = (qCnt_r == QTR_LAST);
  wire stalled = (ph_r == 2'h3) && !sclSync_r;
  wire step = tick && !stalled;
  wire ackBit = (idx_r == ADDR_ACK_BIT) || (!rd_r && idx_r == LAST_BIT);
  wire rxBit = rd_r && idx_r >= FIRST_RX_BIT && idx_r <= LAST_RX_BIT;

  always_ff @(posedge clk) begin
    // Quarter restarts once a stretched clock reads high, so the high time stays whole
    if (srst || state_r == H_IDLE || tick || stalled) begin
      qCnt_r <= 8'h00;
    end else begin
      qCnt_r <= qCnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    done_r <= 1'b0;
    if (srst) begin
      state_r <= H_IDLE;
      ph_r <= 2'h0;
      idx_r <= 5'h00;
      frame_r <= '0;
      sclOe_r <= 1'b0;
      sdaOe_r <= 1'b0;
      nack_r <= 1'b0;
      rd_r <= 1'b0;
      rx_r <= 8'h00;
    end else begin
      case (state_r)
        H_IDLE: if (req) begin
          // Address, r/w, ack slot, data or released, final ack slot
          frame_r <= {SLAVE_ADDR, rdNotWr, 1'b1, rdNotWr ? 8'hff : wrByte, 1'b1};
          rd_r <= rdNotWr;
          nack_r <= 1'b0;
          state_r <= H_START;
        end
        H_START: if (tick) begin
          sdaOe_r <= 1'b1;
          ph_r <= 2'h0;
          idx_r <= 5'h00;
          state_r <= H_BIT;
        end
        H_BIT: if (step) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) sclOe_r <= 1'b1;
          if (ph_r == 2'h1) sdaOe_r <= !frame_r[17];
          if (ph_r == 2'h2) sclOe_r <= 1'b0;
          if (ph_r == 2'h3) begin
            frame_r <= {frame_r[16:0], 1'b0};
            if (ackBit && sdaSync_r) nack_r <= 1'b1;
            if (rxBit) rx_r <= {rx_r[6:0], sdaSync_r};
            if (idx_r == LAST_BIT) begin
              state_r <= H_STOP;
            end else begin
              idx_r <= idx_r + 5'h01;
            end
          end
        end
        H_STOP: if (step) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) sclOe_r <= 1'b1;
          if (ph_r == 2'h1) sdaOe_r <= 1'b1;
          if (ph_r == 2'h2) sclOe_r <= 1'b0;
          if (ph_r == 2'h3) begin
            sdaOe_r <= 1'b0;
            done_r <= 1'b1;
            state_r <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign link.hostSclO = 1'b0;
  assign link.hostSdaO = 1'b0;
  assign link.hostSclOe = sclOe_r;
  assign link.hostSdaOe = sdaOe_r;
  assign busy = (state_r != H_IDLE);
  assign done = done_r;
  assign nack = nack_r;
  assign rdByte = rx_r;
  assign msgPendingSeen = ntfSync_r;
endmodule

// ===== ihc_device.sv
// Device end: command slave port, master port and notify pin
// Functional notes
// - Separate slave and master two-wire pin pairs
// - Fast mode, at most 400 kbit/s
// - Eight-bit bytes, most significant bit first
// - Receiver acknowledges every byte; the host releases the final ack slot of a read
// - Device stretches clock low while busy
// - Writes deliver commands, reads return status
// - Notify pin flags a pending message
// - Answer only the fixed address 0x40
// - Filter spikes under 50 ns on the slave pin pair; master pins are only synchronised
module ihc_device (
  input wire logic clk,
  input wire logic srst,
  ihc_if.dev link,
  output ihc_pkg::ihc_byte_t cmdByte,
  output logic cmdValid,
  input wire ihc_pkg::ihc_byte_t statusByte,
  output logic statusTaken,
  input wire logic busyHold,
  input wire logic msgPending,
  input wire logic mReq,
  input wire ihc_pkg::ihc_addr_t mAddr,
  input wire ihc_pkg::ihc_byte_t mData,
  output logic mBusy,
  output logic mDone,
  output logic mNack,
  input wire logic mSclIn,
  input wire logic mSdaIn,
  output logic mSclO,
  output logic mSclOe,
  output logic mSdaO,
  output logic mSdaOe
);
  import ihc_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WR, S_RD, S_SKIP} ihc_sstate_e;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} ihc_mstate_e;

  // ==========================================
  // Slave pin sync and spike filter, index 0 clock, 1 data
  logic [1:0] lineMeta_r, lineSync_r, lineF_r, lineFd_r;
  logic [3:0] fltCnt_r [2];
  always_ff @(posedge clk) begin
    lineMeta_r <= {link.sda, link.scl};
    lineSync_r <= lineMeta_r;
  end

  // A change must hold for the full spike width before it is seen
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (srst) begin
        lineF_r[i] <= 1'b1;
        fltCnt_r[i] <= 4'h0;
      end else if (lineSync_r[i] == lineF_r[i]) begin
        fltCnt_r[i] <= 4'h0;
      end else if (fltCnt_r[i] == SPIKE_LAST) begin
        lineF_r[i] <= lineSync_r[i];
        fltCnt_r[i] <= 4'h0;
      end else begin
        fltCnt_r[i] <= fltCnt_r[i] + 4'h1;
      end
    end
    lineFd_r <= srst ? 2'h3 : lineF_r;
  end

  wire sclF = lineF_r[0];
  wire sdaF = lineF_r[1];
  wire sclRise = sclF && !lineFd_r[0];
  wire sclFall = !sclF && lineFd_r[0];
  wire startCond = sclF && lineFd_r[0] && lineFd_r[1] && !sdaF;
  wire stopCond = sclF && lineFd_r[0] && !lineFd_r[1] && sdaF;

  // ==========================================
  // Slave byte engine
  ihc_sstate_e sState_r;
  logic [3:0] bitCnt_r;
  ihc_byte_t shift_r, txShift_r, cmdByte_r;
  logic sdaOe_r, sclOe_r, hostAck_r, cmdValid_r, statusTaken_r, notify_r;
  wire active = (sState_r != S_IDLE) && (sState_r != S_SKIP);
  wire addrHit = (shift_r[7:1] == SLAVE_ADDR);
  wire loadTx = (sState_r == S_ADDR && shift_r[0]) || (sState_r == S_RD && hostAck_r);

  always_ff @(posedge clk) begin
    cmdValid_r <= 1'b0;
    statusTaken_r <= 1'b0;
    if (srst) begin
      sState_r <= S_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      txShift_r <= 8'h00;
      cmdByte_r <= 8'h00;
      sdaOe_r <= 1'b0;
      hostAck_r <= 1'b0;
    end else if (startCond) begin
      sState_r <= S_ADDR;
      // First fall after start only opens bit 0, so it must not count
      bitCnt_r <= 4'hf;
      sdaOe_r <= 1'b0;
    end else if (stopCond) begin
      sState_r <= S_IDLE;
      sdaOe_r <= 1'b0;
    end else if (active) begin
      if (sclRise && bitCnt_r != ACK_SLOT) shift_r <= {shift_r[6:0], sdaF};
      if (sclRise && bitCnt_r == ACK_SLOT) hostAck_r <= !sdaF;
      if (sclFall && bitCnt_r == ACK_SLOT) begin
        bitCnt_r <= 4'h0;
        sdaOe_r <= 1'b0;
        if (sState_r == S_ADDR) sState_r <= shift_r[0] ? S_RD : S_WR;
        if (sState_r == S_RD && !hostAck_r) sState_r <= S_SKIP;
        if (loadTx) begin
          txShift_r <= statusByte;
          sdaOe_r <= !statusByte[7];
          statusTaken_r <= 1'b1;
        end
      end else if (sclFall) begin
        bitCnt_r <= bitCnt_r + 4'h1;
        if (bitCnt_r == LAST_DATA_BIT) begin
          if (sState_r == S_ADDR && !addrHit) begin
            sState_r <= S_SKIP;
          end else begin
            sdaOe_r <= (sState_r != S_RD);
          end
          if (sState_r == S_WR) begin
            cmdByte_r <= shift_r;
            cmdValid_r <= 1'b1;
          end
        end else if (sState_r == S_RD) begin
          sdaOe_r <= !txShift_r[6];
          txShift_r <= {txShift_r[6:0], 1'b0};
        end
      end
    end
  end

  // Stretch starts only at a seen fall: the filter lags the pin, so a later start could clip a high
  always_ff @(posedge clk) begin
    if (srst) begin
      sclOe_r <= 1'b0;
      notify_r <= 1'b0;
    end else begin
      sclOe_r <= busyHold && active && (sclOe_r || sclFall);
      notify_r <= msgPending;
    end
  end

  assign link.devSclO = 1'b0;
  assign link.devSdaO = 1'b0;
  assign link.devSclOe = sclOe_r;
  assign link.devSdaOe = sdaOe_r;
  assign link.messagePendingNotifyPin = notify_r;
  assign cmdByte = cmdByte_r;
  assign cmdValid = cmdValid_r;
  assign statusTaken = statusTaken_r;

  // ==========================================
  // Master port on its own pin pair, one byte write per request
  logic mSclMeta_r, mSclSync_r, mSdaMeta_r, mSdaSync_r;
  always_ff @(posedge clk) begin
    mSclMeta_r <= mSclIn;
    mSclSync_r <= mSclMeta_r;
    mSdaMeta_r <= mSdaIn;
    mSdaSync_r <= mSdaMeta_r;
  end

  ihc_mstate_e mState_r;
  logic [7:0] qCnt_r;
  logic [1:0] ph_r;
  logic [4:0] idx_r;
  logic [17:0] frame_r;
  logic mSclOe_r, mSdaOe_r, mDone_r, mNack_r;
  wire tick = (qCnt_r == QTR_LAST);
  wire mStalled = (ph_r == 2'h3) && !mSclSync_r;
  wire step = tick && !mStalled;
  wire ackBit = (idx_r == ADDR_ACK_BIT) || (idx_r == LAST_BIT);

  always_ff @(posedge clk) begin
    if (srst || mState_r == M_IDLE || tick || mStalled) begin
      qCnt_r <= 8'h00;
    end else begin
      qCnt_r <= qCnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    mDone_r <= 1'b0;
    if (srst) begin
      mState_r <= M_IDLE;
      ph_r <= 2'h0;
      idx_r <= 5'h00;
      frame_r <= '0;
      mSclOe_r <= 1'b0;
      mSdaOe_r <= 1'b0;
      mNack_r <= 1'b0;
    end else begin
      case (mState_r)
        M_IDLE: if (mReq) begin
          frame_r <= {mAddr, 1'b0, 1'b1, mData, 1'b1};
          mNack_r <= 1'b0;
          mState_r <= M_START;
        end
        M_START: if (tick) begin
          mSdaOe_r <= 1'b1;
          ph_r <= 2'h0;
          idx_r <= 5'h00;
          mState_r <= M_BIT;
        end
        M_BIT: if (step) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) mSclOe_r <= 1'b1;
          if (ph_r == 2'h1) mSdaOe_r <= !frame_r[17];
          if (ph_r == 2'h2) mSclOe_r <= 1'b0;
          if (ph_r == 2'h3) begin
            frame_r <= {frame_r[16:0], 1'b0};
            if (ackBit && mSdaSync_r) mNack_r <= 1'b1;
            if (idx_r == LAST_BIT) begin
              mState_r <= M_STOP;
            end else begin
              idx_r <= idx_r + 5'h01;
            end
          end
        end
        M_STOP: if (step) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) mSclOe_r <= 1'b1;
          if (ph_r == 2'h1) mSdaOe_r <= 1'b1;
          if (ph_r == 2'h2) mSclOe_r <= 1'b0;
          if (ph_r == 2'h3) begin
            mSdaOe_r <= 1'b0;
            mDone_r <= 1'b1;
            mState_r <= M_IDLE;
          end
        end
        default: mState_r <= M_IDLE;
      endcase
    end
  end

  assign mSclO = 1'b0;
  assign mSdaO = 1'b0;
  assign mSclOe = mSclOe_r;
  assign mSdaOe = mSdaOe_r;
  assign mBusy = (mState_r != M_IDLE);
  assign mDone = mDone_r;
  assign mNack = mNack_r;
endmodule

// ===== ihc_assertions.sv
// Pin-level protocol checker for the host command port
module ihc_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic hostSdaOe,
  input wire logic devSclOe,
  input wire logic devSdaOe,
  input wire logic messagePendingNotifyPin
);
  // ========
  // Line history
  logic sclQ_r;
  logic sdaQ_r;
  logic inFrame_r;
  logic [9:0] sinceRise_r;
  wire sclRise = scl & ~sclQ_r;
  wire startSeen = scl & sclQ_r & sdaQ_r & ~sda;
  wire stopSeen = scl & sclQ_r & ~sdaQ_r & sda;
  wire [9:0] riseNxt = (sinceRise_r == 10'h3ff) ? sinceRise_r : sinceRise_r + 10'h001;
  always_ff @(posedge clk) begin
    sclQ_r <= srst | scl;
    sdaQ_r <= srst | sda;
    inFrame_r <= ~srst & (startSeen | (inFrame_r & ~stopSeen));
    // Saturates so the first rise after reset always passes
    sinceRise_r <= srst ? 10'h3ff : (sclRise ? 10'h001 : riseNxt);
  end
  // ========
  // Properties
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_rate;
    sclRise |-> sinceRise_r >= 10'h271;
  endproperty
  a_rate: assert property (p_rate) else $error("scl period below fast mode");
  property p_dev_stable_high;
    scl && sclQ_r |-> $stable(devSdaOe);
  endproperty
  a_dev_stable_high: assert property (p_dev_stable_high) else $error("device data moved with scl high");
  property p_hold;
    $fell(scl) |=> $stable(sda) [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("sda hold too short");
  property p_host_setup;
    $changed(hostSdaOe) && scl |-> $past(scl, 25);
  endproperty
  a_host_setup: assert property (p_host_setup) else $error("host sda edge too near scl rise");
  property p_drive_after_fall;
    $rose(devSdaOe) |-> !$past(scl, 12) && $past(scl, 24);
  endproperty
  a_drive_after_fall: assert property (p_drive_after_fall) else $error("device drive not after scl fall");
  property p_stretch_low;
    $rose(devSclOe) |-> !$past(scl);
  endproperty
  a_stretch_low: assert property (p_stretch_low) else $error("stretch began with scl high");
  property p_frame;
    devSdaOe |-> inFrame_r;
  endproperty
  a_frame: assert property (p_frame) else $error("device drove sda outside a frame");
  property p_notify;
    $changed(messagePendingNotifyPin) |=> $stable(messagePendingNotifyPin) [*2];
  endproperty
  a_notify: assert property (p_notify) else $error("notify pin glitched");
  c_stretch: cover property ($rose(devSclOe));
  c_ack: cover property ($rose(devSdaOe));
  c_stop: cover property (stopSeen);
endmodule

// ===== tb_i2c_host_command_port.sv
// Self-checking bench joining host and device ends
module tb_i2c_host_command_port;
  timeunit 1ns;
  timeprecision 100ps;
  import ihc_pkg::*;
  typedef struct {logic rd; ihc_byte_t wb; ihc_byte_t st;} ihc_row_s;
  logic clk = 1'b0, srst = 1'b1, req = 1'b0, rdNotWr = 1'b0, busyHold = 1'b0;
  logic msgPending = 1'b0, mReq = 1'b0, spike = 1'b0;
  logic busy, done, nack, msgPendingSeen, cmdValid, statusTaken, mBusy, mDone, mNack, mSclOe, mSdaOe, cmdValid2;
  ihc_addr_t mAddr = 7'h22;
  ihc_byte_t wrByte = 8'h00, statusByte = 8'h00, mData = 8'h96, rdByte, cmdByte, lastCmd, cmdByte2, lastCmd2;
  int err_count = 0, checks_done = 0, nCmd = 0, nTaken = 0, nCmd2 = 0, nMDone = 0, waitCyc;
  ihc_row_s rows[4] = '{'{1'b0, 8'hc4, 8'h00}, '{1'b0, 8'h37, 8'h00}, '{1'b1, 8'h00, 8'h1e}, '{1'b1, 8'h00, 8'hb2}};
  always #2 clk = ~clk;
  // Master pair runs to a second device; spike adds a short low pulse on its clock
  ihc_if link2 ();
  assign link2.hostSclO = 1'b0;
  assign link2.hostSdaO = 1'b0;
  assign link2.hostSclOe = mSclOe | spike;
  assign link2.hostSdaOe = mSdaOe;
  ihc_if link ();
  ihc_host i_ihc_host (.clk(clk), .srst(srst), .link(link.host), .req(req), .rdNotWr(rdNotWr),
    .wrByte(wrByte), .busy(busy), .done(done), .nack(nack), .rdByte(rdByte), .msgPendingSeen(msgPendingSeen));
  ihc_device i_ihc_device (.clk(clk), .srst(srst), .link(link.dev), .cmdByte(cmdByte), .cmdValid(cmdValid),
    .statusByte(statusByte), .statusTaken(statusTaken), .busyHold(busyHold), .msgPending(msgPending),
    .mReq(mReq), .mAddr(mAddr), .mData(mData), .mBusy(mBusy), .mDone(mDone), .mNack(mNack),
    .mSclIn(link2.scl), .mSdaIn(link2.sda), .mSclO(), .mSclOe(mSclOe), .mSdaO(), .mSdaOe(mSdaOe));
  ihc_device i_ihc_device_far (.clk(clk), .srst(srst), .link(link2.dev), .cmdByte(cmdByte2), .cmdValid(cmdValid2),
    .statusByte(8'h00), .statusTaken(), .busyHold(1'b0), .msgPending(1'b0), .mReq(1'b0), .mAddr(7'h00),
    .mData(8'h00), .mBusy(), .mDone(), .mNack(), .mSclIn(1'b1), .mSdaIn(1'b1), .mSclO(), .mSclOe(), .mSdaO(),
    .mSdaOe());
  ihc_assertions i_ihc_assertions (.clk(clk), .srst(srst), .scl(link.scl), .sda(link.sda),
    .hostSdaOe(link.hostSdaOe), .devSclOe(link.devSclOe), .devSdaOe(link.devSdaOe),
    .messagePendingNotifyPin(link.messagePendingNotifyPin));
  always @(posedge clk) begin
    if (cmdValid === 1'b1) begin
      lastCmd <= cmdByte;
      nCmd <= nCmd + 1;
    end
    if (statusTaken === 1'b1) nTaken <= nTaken + 1;
    if (mDone === 1'b1) nMDone <= nMDone + 1;
    if (cmdValid2 === 1'b1) begin
      lastCmd2 <= cmdByte2;
      nCmd2 <= nCmd2 + 1;
    end
  end
  // ========
  // Checking and transfers
  task automatic close_out();
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmpByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpBit(input string what, input logic exp, input logic got);
    cmpByte(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic xfer(input logic rd, input ihc_byte_t wb);
    @(negedge clk);
    rdNotWr = rd;
    wrByte = wb;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    waitCyc = 0;
    while (done !== 1'b1) begin
      @(negedge clk);
      waitCyc++;
      if (waitCyc > 30000) begin
        cmpBit("done", 1'b1, 1'b0);
        close_out();
      end
    end
  endtask
  task automatic waitScl2(input logic lvl);
    int n;
    n = 0;
    while (link2.scl !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 2000) begin
        cmpBit("far scl", lvl, link2.scl);
        close_out();
      end
    end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    cmpBit("lines pulled", 1'b0, link.hostSclOe | link.hostSdaOe | link.devSclOe | link.devSdaOe);
    cmpBit("done", 1'b0, done);
    mReq = 1'b1;
    @(negedge clk);
    cmpBit("mBusy", 1'b1, mBusy);
    mReq = 1'b0;
    foreach (rows[i]) begin
      statusByte = rows[i].st;
      xfer(rows[i].rd, rows[i].wb);
      cmpBit("nack", 1'b0, nack);
      if (rows[i].rd) cmpByte("rdByte", rows[i].st, rdByte);
      else cmpByte("cmdByte", rows[i].wb, lastCmd);
    end
    cmpByte("cmd count", 8'h02, 8'(nCmd));
    cmpByte("status count", 8'h02, 8'(nTaken));
    cmpByte("mDone count", 8'h01, 8'(nMDone));
    cmpBit("mNack", 1'b1, mNack);
    cmpBit("mBusy", 1'b0, mBusy);
    cmpByte("far cmd count", 8'h00, 8'(nCmd2));
    fork
      xfer(1'b0, 8'h69);
      begin
        repeat (2000) @(negedge clk);
        busyHold = 1'b1;
        msgPending = 1'b1;
        repeat (4) @(negedge clk);
        cmpBit("notify", 1'b1, link.messagePendingNotifyPin);
        cmpBit("seen", 1'b1, msgPendingSeen);
        msgPending = 1'b0;
        repeat (6000) @(negedge clk);
        cmpBit("notify", 1'b0, link.messagePendingNotifyPin);
        cmpBit("scl", 1'b0, link.scl);
        cmpBit("busy", 1'b1, busy);
        busyHold = 1'b0;
      end
      begin
        mAddr = SLAVE_ADDR;
        mData = 8'h5a;
        mReq = 1'b1;
        @(negedge clk);
        mReq = 1'b0;
        waitScl2(1'b0);
        waitScl2(1'b1);
        // 40 ns low pulse inside the first high phase
        repeat (40) @(negedge clk);
        spike = 1'b1;
        repeat (10) @(negedge clk);
        spike = 1'b0;
      end
    join
    cmpBit("stretched", 1'b1, waitCyc > 15000);
    cmpByte("cmdByte", 8'h69, lastCmd);
    cmpBit("mNack", 1'b0, mNack);
    cmpByte("far cmdByte", 8'h5a, lastCmd2);
    cmpByte("mDone count", 8'h02, 8'(nMDone));
    close_out();
  end
endmodule
